// file: verilog/tvdac_pkg.sv
// Operation
// RULE1: latch three codes and blank every clock rise
// RULE2: blank low forces all outputs to blanking
// RULE3: code bit zero is lsb, nine msb
// RULE4: source ties unused code bits low
// RULE5: generic mode: no bias, code zero is zero volts
// RULE6: sync insertion adds half-swing dc bias
// RULE7: rgb mode blanks every channel at code zero
// RULE8: ypbpr blanks red/blue at 512, green zero
// RULE9: type select low enables sync insertion
// RULE10: ypbpr routes sync to colour strap too
// RULE11: reserved strap held low in every mode
// RULE12: sync low forces green sync tip only
// RULE13: video to sync amplitude kept at 7:3
// RULE14: video to blank amplitude kept at 2:1
// RULE15: blanking works in every mode
// RULE16: generic mode source holds blank high; the pixel source model still drops blank in generic mode
// RULE17: sync latched with the pixel codes
package tvdac_pkg;

   // pixel code geometry
   localparam int unsigned TVDAC_CODE_W = 10;
   localparam int unsigned TVDAC_CHANS = 3;
   localparam int unsigned TVDAC_CH_RED = 0;
   localparam int unsigned TVDAC_CH_GREEN = 1;
   localparam int unsigned TVDAC_CH_BLUE = 2;
   localparam int unsigned TVDAC_CODE_MAX = 1023;

   // blanking codes
   localparam logic [9:0] TVDAC_CODE_ZERO = 10'h000;
   localparam logic [9:0] TVDAC_CODE_MID = 10'h200;

   // output levels in millivolts at nominal full scale
   localparam int unsigned TVDAC_FS_MV = 700;
   localparam int unsigned TVDAC_BIAS_MV = TVDAC_FS_MV / 2;
   localparam int unsigned TVDAC_SYNC_MV = (TVDAC_FS_MV * 3) / 7;
   localparam int unsigned TVDAC_LVL_W = 11;

   // elastic buffer between capture and output stage
   localparam int unsigned TVDAC_FIFO_DEPTH = 16;

   // reset values of the output stage
   localparam logic [10:0] TVDAC_LVL_RST = 11'h000;
   localparam logic [9:0] TVDAC_CODE_RST = 10'h000;

   // decoded operating mode
   typedef enum logic [1:0] {
      tvdac_mode_generic,
      tvdac_mode_rgb,
      tvdac_mode_ypbpr
   } tvdac_mode_t;

   // one latched pixel with its controls and decoded mode
   typedef struct packed {
      logic [TVDAC_CHANS-1:0][TVDAC_CODE_W-1:0] code;
      logic blank_n;
      logic sync_n;
      tvdac_mode_t mode;
      logic fault;
   } tvdac_sample_t;

   // what one converter channel is told to produce
   typedef struct packed {
      logic [TVDAC_CODE_W-1:0] code;
      logic [TVDAC_LVL_W-1:0] level_mv;
      logic bias_on;
      logic sync_tip;
   } tvdac_chan_t;

endpackage

// file: verilog/tvdac_fifo.sv
`timescale 1ns/10ps
// flop based fifo with valid/ready on both sides
module tvdac_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   // pointer wrap relies on a power of two depth
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("tvdac_fifo: depth must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_ff [DEPTH]; // storage, one word per entry
   logic [AW:0] wr_ptr_ff; // extra bit tells full from empty
   logic [AW:0] rd_ptr_ff;
   wire logic push;
   wire logic pop;
   wire logic full;
   wire logic empty;

   // full when pointers differ only in the wrap bit
   assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   assign empty = (wr_ptr_ff == rd_ptr_ff);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;
   assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

   // storage write, no reset needed on data
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end

endmodule

// file: verilog/tvdac_top.sv
`timescale 1ns/10ps
// input latch, mode decode and level control of a triple video converter
module tvdac_top
   import tvdac_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = TVDAC_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [TVDAC_CODE_W-1:0] red_pixel_code,
   input wire logic [TVDAC_CODE_W-1:0] green_pixel_code,
   input wire logic [TVDAC_CODE_W-1:0] blue_pixel_code,
   input wire logic blank_n,
   input wire logic sync_n,
   input wire logic sync_type_select,
   input wire logic colour_space_strap,
   input wire logic reserved_strap_low,
   input wire logic output_stall,
   input wire logic overrun_clear,
   output tvdac_chan_t red_channel_out,
   output tvdac_chan_t green_channel_out,
   output tvdac_chan_t blue_channel_out,
   output logic out_valid,
   output tvdac_mode_t mode_out,
   output logic strap_fault,
   output logic pixel_ready,
   output logic overrun
);

   // the buffer needs room for at least a couple of pixels
   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("tvdac_top: fifo depth below two");
      end
   end

   localparam int unsigned SAMPLE_W = $bits(tvdac_sample_t);

   // scale a code to millivolts, rounded to nearest
   function automatic logic [TVDAC_LVL_W-1:0] code_to_mv(input logic [TVDAC_CODE_W-1:0] c);
      int unsigned prod;
      prod = (int'(c) * TVDAC_FS_MV + TVDAC_CODE_MAX / 2) / TVDAC_CODE_MAX;
      return prod[TVDAC_LVL_W-1:0];
   endfunction

   // constant levels derived once
   localparam logic [TVDAC_LVL_W-1:0] BIAS_LVL = TVDAC_LVL_W'(TVDAC_BIAS_MV);
   localparam logic [TVDAC_LVL_W-1:0] TIP_LVL = TVDAC_LVL_W'(TVDAC_BIAS_MV - TVDAC_SYNC_MV);
   localparam logic [TVDAC_LVL_W-1:0] ZERO_LVL = TVDAC_LVL_W'(0);

   // ------------------------------------------------------------------
   // mode decode from the raw strap pins
   // ------------------------------------------------------------------
   // sync type select low turns insertion on; colour strap picks ypbpr
   wire logic ins_on; // sync insertion requested
   wire logic raw_fault; // strap combination the device does not define
   wire tvdac_mode_t raw_mode;

   assign ins_on = !sync_type_select; // RULE9
   // reserved strap must be low, and generic mode wants the colour strap low
   assign raw_fault = reserved_strap_low || (!ins_on && colour_space_strap); // RULE11
   // in ypbpr the colour strap follows sync, so it drops during a sync
   // pulse; red and blue then blank at code zero, which is what the part does
   assign raw_mode = !ins_on ? tvdac_mode_generic :
                     (colour_space_strap ? tvdac_mode_ypbpr : tvdac_mode_rgb); // RULE10

   // ------------------------------------------------------------------
   // input latch: codes, blank, sync and mode on the same edge
   // ------------------------------------------------------------------
   tvdac_sample_t cap_ff; // latched pixel
   logic cap_valid_ff; // first sample exists one edge after reset
   tvdac_sample_t nxt_cap;

   // bit index zero of each bus is kept as the lsb all the way through
   assign nxt_cap.code[TVDAC_CH_RED] = red_pixel_code; // RULE3
   assign nxt_cap.code[TVDAC_CH_GREEN] = green_pixel_code;
   assign nxt_cap.code[TVDAC_CH_BLUE] = blue_pixel_code;
   assign nxt_cap.blank_n = blank_n;
   assign nxt_cap.sync_n = sync_n; // RULE17
   assign nxt_cap.mode = raw_mode;
   assign nxt_cap.fault = raw_fault;

   // latch every rising edge, no enable: the source has no wait state
   always_ff @(posedge clock) begin
      if (rst) begin
         cap_ff <= '0;
         cap_valid_ff <= 1'b0;
      end else begin
         cap_ff <= nxt_cap; // RULE1
         cap_valid_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // elastic buffer between latch and output stage
   // ------------------------------------------------------------------
   wire logic fifo_in_ready; // buffer can take the latched pixel
   wire logic fifo_out_valid; // buffer holds a pixel for the output stage
   wire logic [SAMPLE_W-1:0] fifo_out_data;
   wire logic drain; // output stage takes a pixel this cycle
   wire tvdac_sample_t cur; // pixel at the buffer head

   assign drain = fifo_out_valid && !output_stall;
   assign cur = tvdac_sample_t'(fifo_out_data);

   tvdac_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(cap_valid_ff),
      .in_ready(fifo_in_ready),
      .in_data(cap_ff),
      .out_valid(fifo_out_valid),
      .out_ready(drain),
      .out_data(fifo_out_data)
   );

   // ready and overrun back to the source; a pixel offered while full is lost
   logic pixel_ready_ff;
   logic overrun_ff; // sticky, set wins over clear
   wire logic lost; // latched pixel refused by a full buffer

   assign lost = cap_valid_ff && !fifo_in_ready;

   always_ff @(posedge clock) begin
      if (rst) begin
         pixel_ready_ff <= 1'b0;
         overrun_ff <= 1'b0;
      end else begin
         pixel_ready_ff <= fifo_in_ready;
         overrun_ff <= lost || (overrun_ff && !overrun_clear);
      end
   end

   // ------------------------------------------------------------------
   // level generation, one copy per channel
   // ------------------------------------------------------------------
   wire logic bias_on; // dc bias current enabled
   wire logic blanking; // latched blank is asserted
   wire logic cur_ypbpr;

   // a fault falls back to generic so no bias or sync is produced
   assign bias_on = (cur.mode != tvdac_mode_generic) && !cur.fault; // RULE6 RULE5
   assign cur_ypbpr = (cur.mode == tvdac_mode_ypbpr) && !cur.fault;
   assign blanking = !cur.blank_n; // RULE15

   tvdac_chan_t chan_ff [TVDAC_CHANS]; // registered channel commands
   tvdac_chan_t nxt_chan [TVDAC_CHANS];

   for (genvar ch = 0; ch < TVDAC_CHANS; ch++) begin : g_chan
      localparam bit IS_GREEN = (ch == TVDAC_CH_GREEN);
      wire logic mid_blank; // channel blanks at mid scale
      wire logic [TVDAC_CODE_W-1:0] blank_code;
      wire logic [TVDAC_CODE_W-1:0] eff_code;
      wire logic tip; // green held at sync tip
      wire logic [TVDAC_LVL_W-1:0] video_mv;
      wire logic [TVDAC_LVL_W-1:0] offset_mv;
      wire logic [TVDAC_LVL_W-1:0] ref_mv;

      // ypbpr centres the colour difference channels on code 512
      assign mid_blank = cur_ypbpr && !IS_GREEN; // RULE8
      // generic and rgb both blank at code zero
      assign blank_code = mid_blank ? TVDAC_CODE_MID : TVDAC_CODE_ZERO; // RULE7 RULE5
      // blank overrides the data code whatever its value
      assign eff_code = blanking ? blank_code : cur.code[ch]; // RULE2
      // sync reaches only the green channel and only with bias on
      assign tip = IS_GREEN && bias_on && !cur.sync_n; // RULE12
      assign video_mv = code_to_mv(eff_code);
      // bias is half the swing, so blank sits at 2:1 under full video
      assign offset_mv = bias_on ? BIAS_LVL : ZERO_LVL; // RULE14
      // mid-scale reference cancels so code 512 lands on the bias level
      assign ref_mv = mid_blank ? code_to_mv(TVDAC_CODE_MID) : ZERO_LVL;

      always_comb begin
         nxt_chan[ch].code = eff_code;
         nxt_chan[ch].bias_on = bias_on;
         nxt_chan[ch].sync_tip = tip;
         if (tip) begin
            // sync tip is 3/7 of the swing below the blank level
            nxt_chan[ch].level_mv = TIP_LVL; // RULE13
         end else begin
            nxt_chan[ch].level_mv = TVDAC_LVL_W'(video_mv + offset_mv - ref_mv);
         end
      end

      // hold the last level while stalled, like a real converter would
      always_ff @(posedge clock) begin
         if (rst) begin
            chan_ff[ch] <= '{code: TVDAC_CODE_RST, level_mv: TVDAC_LVL_RST,
                             bias_on: 1'b0, sync_tip: 1'b0};
         end else if (drain) begin
            chan_ff[ch] <= nxt_chan[ch];
         end
      end
   end

   // ------------------------------------------------------------------
   // output stage status
   // ------------------------------------------------------------------
   logic out_valid_ff; // pulses once per pixel taken
   tvdac_mode_t mode_ff;
   logic fault_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         mode_ff <= tvdac_mode_generic;
         fault_ff <= 1'b0;
      end else begin
         out_valid_ff <= drain;
         if (drain) begin
            mode_ff <= cur.fault ? tvdac_mode_generic : cur.mode;
            fault_ff <= cur.fault;
         end
      end
   end

   // every output straight from a flop
   assign red_channel_out = chan_ff[TVDAC_CH_RED];
   assign green_channel_out = chan_ff[TVDAC_CH_GREEN];
   assign blue_channel_out = chan_ff[TVDAC_CH_BLUE];
   assign out_valid = out_valid_ff;
   assign mode_out = mode_ff;
   assign strap_fault = fault_ff;
   assign pixel_ready = pixel_ready_ff;
   assign overrun = overrun_ff;

endmodule

// file: verif/tvdac_monitor.sv
`timescale 1ns/10ps
// passive checks on the converter top ports
module tvdac_monitor
   import tvdac_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [9:0] red_pixel_code,
   input wire logic [9:0] green_pixel_code,
   input wire logic [9:0] blue_pixel_code,
   input wire logic blank_n,
   input wire logic sync_n,
   input wire logic sync_type_select,
   input wire logic colour_space_strap,
   input wire logic reserved_strap_low,
   input wire logic output_stall,
   input wire logic overrun_clear,
   input wire tvdac_chan_t red_channel_out,
   input wire tvdac_chan_t green_channel_out,
   input wire tvdac_chan_t blue_channel_out,
   input wire logic out_valid,
   input wire tvdac_mode_t mode_out,
   input wire logic strap_fault,
   input wire logic pixel_ready,
   input wire logic overrun
);
   default clocking mc @(posedge clock);
   endclocking
   default disable iff (rst);
   // nominal scaling of a code to millivolts, rounded to nearest
   function automatic int scl(logic [9:0] c);
      return (int'(c) * 700 + 511) / 1023;
   endfunction
   // short names for the channels and the mode of the pixel on show
   wire tvdac_chan_t r_w = red_channel_out;
   wire tvdac_chan_t g_w = green_channel_out;
   wire tvdac_chan_t b_w = blue_channel_out;
   wire logic gen_w = out_valid && mode_out == tvdac_mode_generic;
   wire logic rgb_w = out_valid && mode_out == tvdac_mode_rgb;
   wire logic ypb_w = out_valid && mode_out == tvdac_mode_ypbpr;
   gen_level_a: assert property (
      gen_w |-> !r_w.bias_on && !g_w.sync_tip && r_w.level_mv == scl(r_w.code))
      else $error("generic level wrong");
   ins_bias_a: assert property (
      rgb_w || ypb_w |-> r_w.bias_on && g_w.bias_on && b_w.bias_on)
      else $error("bias missing");
   rgb_level_a: assert property (
      rgb_w |-> b_w.level_mv == 350 + scl(b_w.code))
      else $error("rgb level wrong");
   ypb_level_a: assert property (
      ypb_w |-> r_w.level_mv == scl(r_w.code))
      else $error("ypbpr level wrong");
   green_tip_a: assert property (
      out_valid |-> !r_w.sync_tip && !b_w.sync_tip)
      else $error("sync tip off green");
   tip_depth_a: assert property (
      g_w.sync_tip |-> g_w.level_mv == 50)
      else $error("sync tip depth wrong");
   video_swing_a: assert property (
      rgb_w && !g_w.sync_tip |-> g_w.level_mv == 350 + scl(g_w.code))
      else $error("green swing wrong");
   fault_mode_a: assert property (
      out_valid && strap_fault |-> gen_w)
      else $error("fault pixel not generic");
   // a stalled output stage must not present pixels
   stall_idle_a: assert property (output_stall |=> !out_valid)
      else $error("pixel shown while stalled");
   hold_out_a: assert property (!out_valid |-> $stable(g_w) && $stable(mode_out))
      else $error("outputs moved without valid");
endmodule

bind tvdac_top tvdac_monitor u_mon (.*);

// file: verif/tvdac_pixel_source.sv
`timescale 1ns/10ps
// pixel source model: a random word and a mode pick become pin levels
module tvdac_pixel_source (
   input wire logic clock,
   input wire logic [1:0] mode_sel,
   input wire logic [31:0] rnd,
   output logic [9:0] red_pixel_code,
   output logic [9:0] green_pixel_code,
   output logic [9:0] blue_pixel_code,
   output logic blank_n,
   output logic sync_n,
   output logic sync_type_select,
   output logic colour_space_strap,
   output logic reserved_strap_low
);
   // pins settle before the first edge so reset sees no unknowns
   initial {red_pixel_code, green_pixel_code, blue_pixel_code, blank_n, sync_n,
      sync_type_select, colour_space_strap, reserved_strap_low} = '0;
   // generic operation keeps sync parked high
   wire logic nxt_sync_n = rnd[31] || mode_sel == 2'h0;
   // all pins launch together just after the edge
   always @(posedge clock) begin
      {blue_pixel_code, green_pixel_code, red_pixel_code} <= rnd[29:0];
      // blank drops only as a forced blank, otherwise it stays parked high
      blank_n <= rnd[31] || rnd[30];
      sync_n <= nxt_sync_n;
      // the bad strap mode raises each illegal strap on its own and together
      sync_type_select <= mode_sel == 2'h0 || mode_sel == 2'h3;
      colour_space_strap <= (mode_sel == 2'h2 && nxt_sync_n) ||
         (mode_sel == 2'h3 && rnd[30]);
      reserved_strap_low <= mode_sel == 2'h3 && rnd[31];
   end
endmodule

// file: verif/tb_tvdac_top.sv
`timescale 1ns/10ps
// random and corner pixels in every mode, then a buffer stall
module tb_tvdac_top
   import tvdac_pkg::*;
();
   logic clock, rst, output_stall, overrun_clear, out_valid, strap_fault, pixel_ready, overrun;
   logic [1:0] mode_sel;
   logic [31:0] rnd;
   logic [9:0] red_pixel_code, green_pixel_code, blue_pixel_code;
   logic blank_n, sync_n, sync_type_select, colour_space_strap, reserved_strap_low;
   tvdac_chan_t red_channel_out, green_channel_out, blue_channel_out;
   tvdac_mode_t mode_out;
   int n_mismatch = 0;
   int compares = 0;
   bit sb_off = 1'b0; // pixel checks paused while dropped pixels drain
   int unsigned seed_v;
   logic [71:0] exp_v;
   logic [71:0] expq[$];
   // zero, full scale, blank with sync, sync alone, lone bits at both ends
   logic [31:0] corner[5] = '{32'h8000_0000, 32'hbfff_ffff, 32'h0000_0000, 32'h4000_0000,
      32'h9558_0001};
   wire logic [71:0] got_w = {red_channel_out, green_channel_out, blue_channel_out, mode_out,
      strap_fault};
   // small buffer so the stall fills it quickly
   tvdac_top #(.FIFO_DEPTH(4)) dut (.*);
   tvdac_pixel_source src (.*);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // prediction of one pixel from the pin levels at capture
   function automatic logic [71:0] expect_px(logic [29:0] c, logic b, logic s, logic ts,
      logic cs, logic rs);
      tvdac_chan_t ch[3];
      tvdac_mode_t m;
      logic [9:0] e;
      int lv;
      m = (rs || ts) ? tvdac_mode_generic : cs ? tvdac_mode_ypbpr : tvdac_mode_rgb;
      for (int i = 0; i < 3; i++) begin
         e = b ? c[i*10 +: 10] : (m == tvdac_mode_ypbpr && i != 1) ? 10'h200 : 10'h000;
         lv = (int'(e) * 700 + 511) / 1023;
         if (m == tvdac_mode_rgb || (m == tvdac_mode_ypbpr && i == 1)) lv += 350;
         ch[i] = '{e, lv[10:0], m != tvdac_mode_generic, 1'b0};
         if (i == 1 && m != tvdac_mode_generic && !s) ch[i] = '{e, 11'h032, 1'b1, 1'b1};
      end
      return {ch[0], ch[1], ch[2], m, rs || (ts && cs)};
   endfunction
   task automatic chk_px(logic [71:0] got, logic [71:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t pixel got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(logic got, logic exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // every captured pixel is predicted; reset flushes what was in flight
   always @(posedge clock) begin
      if (rst)
         expq.delete();
      else
         expq.push_back(expect_px({blue_pixel_code, green_pixel_code, red_pixel_code},
            blank_n, sync_n, sync_type_select, colour_space_strap, reserved_strap_low));
   end
   // each shown pixel must match the oldest prediction
   always @(negedge clock) begin
      if (out_valid === 1'b1 && !sb_off) begin
         exp_v = (expq.size() > 0) ? expq.pop_front() : ~got_w;
         chk_px(got_w, exp_v);
      end
   end
   initial begin
      seed_v = $urandom(32'haf98_d095);
      rst <= 1'b1;
      {output_stall, overrun_clear, mode_sel, rnd} <= '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk_px(got_w, 72'h0);
      chk_bit(pixel_ready, 1'b0);
      // modes: generic, rgb, ypbpr, bad strap
      for (int m = 0; m < 4; m++) begin
         @(posedge clock);
         mode_sel <= m[1:0];
         for (int k = 0; k < 45; k++) begin
            @(posedge clock);
            rnd <= (k < 5) ? corner[k] : $urandom;
         end
         $display("mode %0d pixels done", m);
      end
      // stall until pixels drop, then clearing must lose to new drops
      @(posedge clock);
      output_stall <= 1'b1;
      for (int k = 0; k < 20 && overrun !== 1'b1; k++) @(negedge clock);
      if (overrun !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED %0t overrun stuck low", $time);
      end
      @(posedge clock);
      overrun_clear <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_bit(overrun, 1'b1);
      chk_bit(pixel_ready, 1'b0);
      chk_bit(out_valid, 1'b0);
      // releasing the stall drains the buffer, so the held clear now wins; pixels dropped
      // in the stall leave the prediction queue out of step until reset flushes it
      sb_off = 1'b1;
      @(posedge clock);
      output_stall <= 1'b0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk_bit(overrun, 1'b0);
      chk_bit(pixel_ready, 1'b1);
      $display("stall test done");
      @(posedge clock);
      {rst, output_stall, overrun_clear, mode_sel} <= 5'h11;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      sb_off = 1'b0;
      repeat (12) @(posedge clock);
      @(negedge clock);
      chk_bit(overrun, 1'b0);
      chk_bit(pixel_ready, 1'b1);
      $display("recovery test done");
      results();
   end
endmodule
